// File: src/reset_cause_status_logic.sv
// reset-cause flags, resume address selection and apb register slave
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module reset_cause_status_logic #(
    parameter int unsigned PC_W = 21
) (
    input  wire logic            clk,
    input  wire logic            sys_rst,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    input  wire logic [3:0]      pstrb,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire logic            brownout_evt,
    input  wire logic            master_clear_pin_n,
    input  wire logic            watchdog_timeout_evt,
    input  wire logic            reset_instr_evt,
    input  wire logic            stack_full_evt,
    input  wire logic            stack_underflow_evt,
    input  wire logic            irq_wake_evt,
    input  wire logic            irq_wake_low_prio,
    input  wire logic            high_priority_irq_enable,
    input  wire logic            low_priority_irq_enable,
    input  wire logic [1:0]      power_mode,
    input  wire logic [PC_W-1:0] current_pc,
    output logic                 core_reset_req,
    output logic                 resume_valid,
    output logic      [PC_W-1:0] resume_pc,
    output logic                 event_irq
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [4:0]      cause;
        logic            stk_full;
        logic            stk_unf;
        logic            ser_en;
        logic [6:0]      evt_stat;
        logic [6:0]      evt_en;
        logic            pin_prev;
        logic            core_reset;
        logic            resume_vld;
        logic [PC_W-1:0] resume_pc;
        logic [31:0]     prdata;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic            acc;
    logic            wr_lane0;
    logic            pin_fall;
    logic            sleepy;
    logic [6:0]      evt_vec;
    logic [6:0]      stat_clr;
    logic [6:0]      stat_next;
    logic [PC_W-1:0] pc_next;

    // one-hot winner of the per-cycle priority among the causes
    typedef enum logic [7:0] {
        SRC_NONE     = 8'h01,
        SRC_BROWNOUT = 8'h02,
        SRC_PIN      = 8'h04,
        SRC_DOG      = 8'h08,
        SRC_INSTR    = 8'h10,
        SRC_SFULL    = 8'h20,
        SRC_SUNF     = 8'h40,
        SRC_WAKE     = 8'h80
    } cause_src_t;

    cause_src_t src;

    // ----------------------------------------------------------------
    // apb decode helpers
    // ----------------------------------------------------------------
    function automatic logic known_addr(input logic [7:0] a);
        logic k;
        k = 1'b0;
        if (a == reset_cause_pkg::OFS_CAUSE)
            k = 1'b1;
        else if (a == reset_cause_pkg::OFS_STACK)
            k = 1'b1;
        else if (a == reset_cause_pkg::OFS_CTRL)
            k = 1'b1;
        else if (a == reset_cause_pkg::OFS_EVT_STAT)
            k = 1'b1;
        else if (a == reset_cause_pkg::OFS_EVT_CLR)
            k = 1'b1;
        else if (a == reset_cause_pkg::OFS_EVT_EN)
            k = 1'b1;
        else if (a == reset_cause_pkg::OFS_RESUME_PC)
            k = 1'b1;
        return k;
    endfunction : known_addr

    function automatic logic [31:0] read_word(
        input logic [7:0] a,
        input state_t     s
    );
        logic [31:0] w;
        w = 32'h00000000;
        if (a == reset_cause_pkg::OFS_CAUSE)
            w[reset_cause_pkg::CAUSE_W-1:0] = s.cause;
        else if (a == reset_cause_pkg::OFS_STACK)
        begin
            w[reset_cause_pkg::STK_FULL_BIT] = s.stk_full;
            w[reset_cause_pkg::STK_UNF_BIT]  = s.stk_unf;
        end
        else if (a == reset_cause_pkg::OFS_CTRL)
            w[reset_cause_pkg::CTRL_SER_BIT] = s.ser_en;
        else if (a == reset_cause_pkg::OFS_EVT_STAT)
            w[reset_cause_pkg::EVT_W-1:0] = s.evt_stat;
        else if (a == reset_cause_pkg::OFS_EVT_EN)
            w[reset_cause_pkg::EVT_W-1:0] = s.evt_en;
        else if (a == reset_cause_pkg::OFS_RESUME_PC)
            w[PC_W-1:0] = s.resume_pc;
        return w;
    endfunction : read_word

    // ----------------------------------------------------------------
    // bus handshake and event conditioning
    // ----------------------------------------------------------------
    // zero wait states: read data is latched during the setup cycle
    assign acc       = psel & penable;
    assign pready    = acc;
    assign pslverr   = acc & ~known_addr(paddr);
    assign wr_lane0  = acc & pwrite & pstrb[0];
    // pin is sampled as a synchronous level; reset is its falling edge
    assign pin_fall  = s_q.pin_prev & ~master_clear_pin_n;
    assign sleepy    = (power_mode == reset_cause_pkg::MODE_IDLE)
                     | (power_mode == reset_cause_pkg::MODE_SLEEP);
    assign pc_next   = current_pc + PC_W'(reset_cause_pkg::PC_STEP);

    always_comb
    begin
        evt_vec = '0;
        evt_vec[reset_cause_pkg::EVT_BO]    = brownout_evt;
        evt_vec[reset_cause_pkg::EVT_PIN]   = pin_fall;
        evt_vec[reset_cause_pkg::EVT_DOG]   = watchdog_timeout_evt;
        evt_vec[reset_cause_pkg::EVT_RST]   = reset_instr_evt;
        evt_vec[reset_cause_pkg::EVT_SFULL] = stack_full_evt;
        evt_vec[reset_cause_pkg::EVT_SUNF]  = stack_underflow_evt;
        // an interrupt at full power is an ordinary interrupt, not a wake
        evt_vec[reset_cause_pkg::EVT_WAKE]  = irq_wake_evt
            & (power_mode != reset_cause_pkg::MODE_FULL);
    end

    // ----------------------------------------------------------------
    // event status: write one to clear, a same-cycle event wins
    // ----------------------------------------------------------------
    always_comb
    begin
        stat_clr = '0;
        if (wr_lane0 && (paddr == reset_cause_pkg::OFS_EVT_CLR))
            stat_clr = pwdata[reset_cause_pkg::EVT_W-1:0];
    end

    for (genvar i = 0; i < reset_cause_pkg::EVT_W; i++)
    begin : g_stat
        assign stat_next[i] = (s_q.evt_stat[i] & ~stat_clr[i]) | evt_vec[i];
    end

    // ----------------------------------------------------------------
    // cause priority
    // ----------------------------------------------------------------
    // only one cause acts per cycle; the losers still mark their status bit
    always_comb
    begin
        if (brownout_evt)
            src = SRC_BROWNOUT;
        else if (pin_fall)
            src = SRC_PIN;
        else if (watchdog_timeout_evt)
            src = SRC_DOG;
        else if (reset_instr_evt)
            src = SRC_INSTR;
        else if (stack_full_evt)
            src = SRC_SFULL;
        else if (stack_underflow_evt)
            src = SRC_SUNF;
        else if (evt_vec[reset_cause_pkg::EVT_WAKE])
            src = SRC_WAKE;
        else
            src = SRC_NONE;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_d            = s_q;
        s_d.core_reset = 1'b0;
        s_d.resume_vld = 1'b0;
        s_d.pin_prev   = master_clear_pin_n;
        s_d.evt_stat   = stat_next;

        // latched in the setup cycle so read data always comes from a flop
        if (psel && !penable)
            s_d.prdata = read_word(paddr, s_q);

        // software writes first, so a same-cycle hardware event wins
        if (wr_lane0)
        begin
            if (paddr == reset_cause_pkg::OFS_CAUSE)
                s_d.cause = pwdata[reset_cause_pkg::CAUSE_W-1:0];
            else if (paddr == reset_cause_pkg::OFS_STACK)
            begin
                s_d.stk_full = pwdata[reset_cause_pkg::STK_FULL_BIT];
                s_d.stk_unf  = pwdata[reset_cause_pkg::STK_UNF_BIT];
            end
            else if (paddr == reset_cause_pkg::OFS_CTRL)
                s_d.ser_en = pwdata[reset_cause_pkg::CTRL_SER_BIT];
            else if (paddr == reset_cause_pkg::OFS_EVT_EN)
                s_d.evt_en = pwdata[reset_cause_pkg::EVT_W-1:0];
        end

        case (src)
            SRC_BROWNOUT:
            begin
                s_d.cause[reset_cause_pkg::INSTR_BIT]    = 1'b1;
                s_d.cause[reset_cause_pkg::DOG_FLAG_BIT] = 1'b1;
                s_d.cause[reset_cause_pkg::PWRDN_BIT]    = 1'b1;
                s_d.cause[reset_cause_pkg::BO_BIT]       = 1'b0;
                s_d.core_reset = 1'b1;
                s_d.resume_vld = 1'b1;
                s_d.resume_pc  = PC_W'(reset_cause_pkg::PC_RESET);
            end
            SRC_PIN:
            begin
                if (sleepy)
                begin
                    s_d.cause[reset_cause_pkg::DOG_FLAG_BIT] = 1'b1;
                    s_d.cause[reset_cause_pkg::PWRDN_BIT]    = 1'b0;
                end
                else if (power_mode == reset_cause_pkg::MODE_RUN)
                    s_d.cause[reset_cause_pkg::DOG_FLAG_BIT] = 1'b1;
                // full power: every flag kept as is
                s_d.core_reset = 1'b1;
                s_d.resume_vld = 1'b1;
                s_d.resume_pc  = PC_W'(reset_cause_pkg::PC_RESET);
            end
            SRC_DOG:
            begin
                s_d.cause[reset_cause_pkg::DOG_FLAG_BIT] = 1'b0;
                s_d.resume_vld = 1'b1;
                if (sleepy)
                begin
                    // a wake, not a reset: the core keeps its state
                    s_d.cause[reset_cause_pkg::PWRDN_BIT] = 1'b0;
                    s_d.resume_pc = pc_next;
                end
                else
                begin
                    s_d.core_reset = 1'b1;
                    s_d.resume_pc  = PC_W'(reset_cause_pkg::PC_RESET);
                end
            end
            SRC_INSTR:
            begin
                s_d.cause[reset_cause_pkg::INSTR_BIT] = 1'b0;
                s_d.core_reset = 1'b1;
                s_d.resume_vld = 1'b1;
                s_d.resume_pc  = PC_W'(reset_cause_pkg::PC_RESET);
            end
            SRC_SFULL:
            begin
                // without the enable this mirrors underflow: flag only
                s_d.stk_full = 1'b1;
                if (s_q.ser_en)
                begin
                    s_d.core_reset = 1'b1;
                    s_d.resume_vld = 1'b1;
                    s_d.resume_pc  = PC_W'(reset_cause_pkg::PC_RESET);
                end
            end
            SRC_SUNF:
            begin
                // with the enable clear this only marks the error
                s_d.stk_unf = 1'b1;
                if (s_q.ser_en)
                begin
                    s_d.core_reset = 1'b1;
                    s_d.resume_vld = 1'b1;
                    s_d.resume_pc  = PC_W'(reset_cause_pkg::PC_RESET);
                end
            end
            SRC_WAKE:
            begin
                s_d.cause[reset_cause_pkg::PWRDN_BIT] = 1'b0;
                s_d.resume_vld = 1'b1;
                // the source's own enable first, then any set enable
                if (high_priority_irq_enable && !irq_wake_low_prio)
                    s_d.resume_pc = PC_W'(reset_cause_pkg::VEC_HIGH);
                else if (low_priority_irq_enable && irq_wake_low_prio)
                    s_d.resume_pc = PC_W'(reset_cause_pkg::VEC_LOW);
                else if (high_priority_irq_enable)
                    s_d.resume_pc = PC_W'(reset_cause_pkg::VEC_HIGH);
                else if (low_priority_irq_enable)
                    s_d.resume_pc = PC_W'(reset_cause_pkg::VEC_LOW);
                else
                    s_d.resume_pc = pc_next;
            end
            default:
            begin
                // no cause this cycle: flags and resume pc hold
                s_d.resume_pc = s_q.resume_pc;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // sys_rst is the power-on reset; core resets never reach these
    // flops, so everything here survives them
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_q <= '{
                cause:      reset_cause_pkg::CAUSE_POR_VAL,
                stk_full:   1'b0,
                stk_unf:    1'b0,
                ser_en:     reset_cause_pkg::CTRL_SER_RST,
                evt_stat:   '0,
                evt_en:     '0,
                pin_prev:   1'b1,
                core_reset: 1'b0,
                resume_vld: 1'b0,
                resume_pc:  PC_W'(reset_cause_pkg::PC_RESET),
                prdata:     32'h00000000
            };
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign prdata         = s_q.prdata;
    assign core_reset_req = s_q.core_reset;
    assign resume_valid   = s_q.resume_vld;
    assign resume_pc      = s_q.resume_pc;
    assign event_irq      = |(s_q.evt_stat & s_q.evt_en);

endmodule : reset_cause_status_logic

`default_nettype wire

// File: src/reset_cause_pkg.sv
// shared constants for the reset-cause status block
package reset_cause_pkg;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W        = 8;
    localparam logic [7:0]  OFS_CAUSE     = 8'h00;
    localparam logic [7:0]  OFS_STACK     = 8'h04;
    localparam logic [7:0]  OFS_CTRL      = 8'h08;
    localparam logic [7:0]  OFS_EVT_STAT  = 8'h0c;
    localparam logic [7:0]  OFS_EVT_CLR   = 8'h10;
    localparam logic [7:0]  OFS_EVT_EN    = 8'h14;
    localparam logic [7:0]  OFS_RESUME_PC = 8'h18;

    // ----------------------------------------------------------------
    // field layouts and reset values
    // ----------------------------------------------------------------
    localparam int unsigned CAUSE_W       = 5;
    localparam int unsigned BO_BIT        = 0;
    localparam int unsigned POR_BIT       = 1;
    localparam int unsigned PWRDN_BIT     = 2;
    localparam int unsigned DOG_FLAG_BIT  = 3;
    localparam int unsigned INSTR_BIT     = 4;
    localparam logic [4:0]  CAUSE_POR_VAL = 5'h1c;
    localparam int unsigned STK_UNF_BIT   = 6;
    localparam int unsigned STK_FULL_BIT  = 7;
    localparam int unsigned CTRL_SER_BIT  = 0;
    localparam logic        CTRL_SER_RST  = 1'h1;

    // ----------------------------------------------------------------
    // event bits of status, clear and enable registers
    // ----------------------------------------------------------------
    localparam int unsigned EVT_W         = 7;
    localparam int unsigned EVT_BO        = 0;
    localparam int unsigned EVT_PIN       = 1;
    localparam int unsigned EVT_DOG       = 2;
    localparam int unsigned EVT_RST       = 3;
    localparam int unsigned EVT_SFULL     = 4;
    localparam int unsigned EVT_SUNF      = 5;
    localparam int unsigned EVT_WAKE      = 6;

    // ----------------------------------------------------------------
    // program counter values and power modes
    // ----------------------------------------------------------------
    localparam logic [20:0] PC_RESET      = 21'h000000;
    localparam logic [20:0] VEC_HIGH      = 21'h000008;
    localparam logic [20:0] VEC_LOW       = 21'h000018;
    localparam logic [20:0] PC_STEP       = 21'h000002;
    localparam logic [1:0]  MODE_FULL     = 2'h0;
    localparam logic [1:0]  MODE_RUN      = 2'h1;
    localparam logic [1:0]  MODE_IDLE     = 2'h2;
    localparam logic [1:0]  MODE_SLEEP    = 2'h3;

endpackage : reset_cause_pkg

// File: testbench/reset_cause_status_logic_asserts.sv
// port-level assertions for the reset-cause block
`timescale 1ns/1ps
`default_nettype none
module reset_cause_status_logic_asserts #(
    parameter int unsigned PC_W = 21
) (
    input wire logic            clk,
    input wire logic            sys_rst,
    input wire logic            brownout_evt,
    input wire logic            master_clear_pin_n,
    input wire logic            watchdog_timeout_evt,
    input wire logic            reset_instr_evt,
    input wire logic            stack_full_evt,
    input wire logic            stack_underflow_evt,
    input wire logic            irq_wake_evt,
    input wire logic            irq_wake_low_prio,
    input wire logic            high_priority_irq_enable,
    input wire logic            low_priority_irq_enable,
    input wire logic [1:0]      power_mode,
    input wire logic [PC_W-1:0] current_pc,
    input wire logic            core_reset_req,
    input wire logic            resume_valid,
    input wire logic [PC_W-1:0] resume_pc
);
    // ----------------------------------------
    // event priority as seen at the pins
    // ----------------------------------------
    logic pin_q;
    logic fall, hi, quiet, wake;
    // history starts high, so a pin held low through reset still counts
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
            pin_q <= 1'b1;
        else
            pin_q <= master_clear_pin_n;
    assign fall = pin_q && !master_clear_pin_n;
    assign hi = brownout_evt || fall;
    assign quiet = !(hi || watchdog_timeout_evt || reset_instr_evt || stack_full_evt
                     || stack_underflow_evt);
    assign wake = quiet && irq_wake_evt && power_mode != 2'h0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    bo_restart_a: assert property (brownout_evt |=> core_reset_req && resume_pc == '0)
        else $error("brown-out did not restart at zero");
    pin_restart_a: assert property (
        fall && !brownout_evt |=> core_reset_req && resume_pc == '0)
        else $error("pin reset did not restart at zero");
    dog_reset_a: assert property (
        !hi && watchdog_timeout_evt && !power_mode[1] |=> core_reset_req && resume_pc == '0)
        else $error("watchdog reset did not restart at zero");
    dog_wake_a: assert property (
        !hi && watchdog_timeout_evt && power_mode[1] |=> resume_valid && !core_reset_req
        && resume_pc == $past(current_pc) + PC_W'(2))
        else $error("watchdog wake resumed wrongly");
    instr_restart_a: assert property (
        !hi && !watchdog_timeout_evt && reset_instr_evt |=> core_reset_req && resume_pc == '0)
        else $error("reset instruction did not restart at zero");
    wake_pc_a: assert property (
        wake && !high_priority_irq_enable && !low_priority_irq_enable |=> resume_valid
        && !core_reset_req && resume_pc == $past(current_pc) + PC_W'(2))
        else $error("interrupt wake did not resume at pc plus two");
    wake_high_a: assert property (
        wake && high_priority_irq_enable && !irq_wake_low_prio
        |=> resume_pc == PC_W'(reset_cause_pkg::VEC_HIGH))
        else $error("high wake vector wrong");
    wake_low_a: assert property (
        wake && low_priority_irq_enable && irq_wake_low_prio
        |=> resume_pc == PC_W'(reset_cause_pkg::VEC_LOW))
        else $error("low wake vector wrong");
    wake_full_a: assert property (
        quiet && irq_wake_evt && power_mode == 2'h0 |=> !resume_valid && !core_reset_req)
        else $error("wake acted at full power");
    idle_quiet_a: assert property (
        quiet && !irq_wake_evt |=> !core_reset_req && !resume_valid)
        else $error("pulse without a cause");

    cover property (core_reset_req);
    cover property (resume_valid && !core_reset_req);
    cover property (wake && high_priority_irq_enable);
endmodule : reset_cause_status_logic_asserts

bind reset_cause_status_logic reset_cause_status_logic_asserts #(
    .PC_W(PC_W)
) i_chk (
    .clk                      (clk),
    .sys_rst                  (sys_rst),
    .brownout_evt             (brownout_evt),
    .master_clear_pin_n       (master_clear_pin_n),
    .watchdog_timeout_evt     (watchdog_timeout_evt),
    .reset_instr_evt          (reset_instr_evt),
    .stack_full_evt           (stack_full_evt),
    .stack_underflow_evt      (stack_underflow_evt),
    .irq_wake_evt             (irq_wake_evt),
    .irq_wake_low_prio        (irq_wake_low_prio),
    .high_priority_irq_enable (high_priority_irq_enable),
    .low_priority_irq_enable  (low_priority_irq_enable),
    .power_mode               (power_mode),
    .current_pc               (current_pc),
    .core_reset_req           (core_reset_req),
    .resume_valid             (resume_valid),
    .resume_pc                (resume_pc)
);
`default_nettype wire

// File: testbench/reset_cause_status_logic_bench.sv
// random and corner-case bench for the reset-cause block
`timescale 1ns/1ps
`default_nettype none
module reset_cause_status_logic_bench;
    logic        clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        hp = 1'b0, lp = 1'b0, lowp = 1'b0, en, er, xr, vx, rq, rv, irq;
    logic        pready, pslverr;
    logic [1:0]  mode = 2'h0, s;
    logic [4:0]  c;
    logic [6:0]  ev = 7'h00, m, ie;
    logic [7:0]  paddr = 8'h00;
    logic [20:0] pc = 21'h000000, rpc, xpc;
    logic [31:0] pwdata = 32'h00000000, prdata, rd, r, seed = 32'h00009c09;
    int          num_errors = 0, num_checks = 0, cyc = 0, k;

    reset_cause_status_logic i_dut (
        .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .brownout_evt(ev[0]), .master_clear_pin_n(!ev[1]),
        .watchdog_timeout_evt(ev[2]), .reset_instr_evt(ev[3]),
        .stack_full_evt(ev[4]), .stack_underflow_evt(ev[5]),
        .irq_wake_evt(ev[6]), .irq_wake_low_prio(lowp),
        .high_priority_irq_enable(hp), .low_priority_irq_enable(lp),
        .power_mode(mode), .current_pc(pc), .core_reset_req(rq),
        .resume_valid(rv), .resume_pc(rpc), .event_irq(irq)
    );

    initial
    begin
        forever #2 clk = ~clk;
    end

    // ----------------------------------------
    // bus, event and expectation helpers
    // ----------------------------------------
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            finish_test();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic check(input string n, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask : check

    // starts one edge later so a release and the next setup never share a time step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic fire(input logic [6:0] mk);
        @(posedge clk);
        ev <= mk;
        @(posedge clk);
        ev <= 7'h00;
        #1;
    endtask : fire

    task automatic model();
        xr = k != 6 && !(k == 2 && mode[1]) && !(k > 3 && !en);
        xpc = (k == 2 && mode[1] || k == 6) ? pc + 21'h2 : 21'h0;
        if (k == 6 && (hp || lp))
            xpc = hp && (!lowp || !lp) ? reset_cause_pkg::VEC_HIGH : reset_cause_pkg::VEC_LOW;
        if (k == 0)
            c = {3'h7, c[1], 1'b0};
        if (k == 1 && mode != 2'h0)
            c[3] = 1'b1;
        if (k == 2)
            c[3] = 1'b0;
        if ((k == 1 || k == 2) && mode[1] || k == 6 && mode != 2'h0)
            c[2] = 1'b0;
        if (k == 3)
            c[4] = 1'b0;
        if (k == 4 || k == 5)
            s[5 - k] = 1'b1;
    endtask : model

    initial
    begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        apb(1'b0, reset_cause_pkg::OFS_CAUSE, 32'h0);
        check("cause", rd, 32'h1c);
        apb(1'b0, reset_cause_pkg::OFS_STACK, 32'h0);
        check("stack", rd, 32'h0);
        apb(1'b0, reset_cause_pkg::OFS_CTRL, 32'h0);
        check("ctrl", rd, 32'h1);
        apb(1'b0, reset_cause_pkg::OFS_RESUME_PC, 32'h0);
        check("resume", rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped", {rd[30:0], er}, 32'h1);
        for (int i = 0; i < 400; i++)
        begin
            r = rnd();
            k = (i == 0) ? 0 : (r[2:0] == 3'h7) ? 6 : r[2:0];
            m = (i == 0) ? 7'h0d : 7'h01 << k;
            mode <= r[4:3];
            hp <= r[5];
            lp <= r[6];
            lowp <= r[7];
            pc <= r[28:8];
            r = rnd();
            {en, ie, s, c} = r[14:0];
            apb(1'b1, reset_cause_pkg::OFS_CTRL, {31'h0, en});
            apb(1'b1, reset_cause_pkg::OFS_CAUSE, {27'h0, c});
            apb(1'b1, reset_cause_pkg::OFS_STACK, {24'h0, s, 6'h0});
            apb(1'b1, reset_cause_pkg::OFS_EVT_EN, {25'h0, ie});
            fire(m);
            model();
            vx = xr || k == 2 || k == 6 && mode != 2'h0;
            check("reset req", rq, xr);
            if (vx || k == 6)
                check("resume valid", rv, vx);
            if (vx)
                check("resume pc", rpc, xpc);
            if (m[6] && mode == 2'h0)
                m = 7'h00;
            check("irq", irq, |(m & ie));
            apb(1'b0, reset_cause_pkg::OFS_CAUSE, 32'h0);
            check("cause", rd, {27'h0, c});
            apb(1'b0, reset_cause_pkg::OFS_STACK, 32'h0);
            check("stack", rd, {24'h0, s, 6'h0});
            apb(1'b0, reset_cause_pkg::OFS_EVT_STAT, 32'h0);
            check("status", rd, {25'h0, m});
            apb(1'b1, reset_cause_pkg::OFS_EVT_CLR, 32'h7f);
            apb(1'b0, reset_cause_pkg::OFS_EVT_STAT, 32'h0);
            check("cleared", {rd[30:0], irq}, 32'h0);
        end
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        apb(1'b0, reset_cause_pkg::OFS_CAUSE, 32'h0);
        check("cause again", rd, 32'h1c);
        apb(1'b0, reset_cause_pkg::OFS_STACK, 32'h0);
        check("stack again", rd, 32'h0);
        finish_test();
    end
endmodule : reset_cause_status_logic_bench
`default_nettype wire
